// file: design/line_unit_pkg.sv
// Shared constants and types for the asynchronous serial line unit
// Summary of operation
// R1 - Dropping transmit enable forces the hold-empty flag high and resets the shifter.
// R2 - Dropping receive enable keeps receive-full, error flags and receive buffer intact.
// R3 - Software disables both directions before changing mode or frame format.
// R4 - An external serial clock must keep running during setup and operation.
// R5 - Clock output starts as soon as the control word selects it.
// R6 - Software waits one bit time after setup before enabling either direction.
// R7 - Enabling takes over the pins: transmitter in mark, receiver idle awaiting start.
// R8 - Enabling transmit first sends one whole frame of ones.
// R9 - Software checks hold-empty, writes the character, then clears hold-empty.
// R10 - In multiprocessor format software writes the ID bit after the character.
// R11 - Clearing hold-empty moves the character to the shifter, sets empty, starts sending.
// R12 - Each frame starts with one zero start bit, then 7 or 8 bits LSB first.
// R13 - Data bits are followed by parity, an ID bit, or nothing.
// R14 - Frames end with one or two ones, line then held high.
// R15 - At stop bit: load next character, or set finished flag and stay in mark.
// R16 - Break is made by port logic before transmit enable is cleared.
// R17 - Receiver syncs on start bit and shifts data LSB first, then parity, stop.
// R18 - Receiver checks the count of ones against even or odd parity.
// R19 - Stop bit must be one; only the first of two stop bits is checked.
// R20 - Passing checks copy the shifter to the receive buffer and set receive-full.
// R21 - A character ending while receive-full is set raises overrun, no copy.
// R22 - Bad stop sets framing fault, bad parity sets parity fault; data still copied.
// R23 - Any receive error blocks reception and receive-full until software clears it.
// R24 - With receive interrupts on, request on receive-full and on any error flag.
// R25 - Each bit is sampled on the 8th of 16 ticks per bit.
// R26 - An external serial clock runs at 16 times the bit rate.
// R27 - Output clock runs at bit rate, rising in the middle of each bit.
// R28 - Multiprocessor format overrides the parity enable.
// R29 - Flags clear by software write; reset leaves both directions idle and disabled. Here tx_finished clears only on the next load.
package line_unit_pkg;

  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_FMT = 5'h04;
  localparam logic [4:0] OFF_BAUD = 5'h08;
  localparam logic [4:0] OFF_FLAGS = 5'h0c;
  localparam logic [4:0] OFF_TXBUF = 5'h10;
  localparam logic [4:0] OFF_RXBUF = 5'h14;

  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [3:0] CLK_OUT_HIGH = 4'h8;

  localparam logic [1:0] CKS_OUT = 2'h1;
  localparam logic [7:0] FMT_WMASK = 8'h7c;
  localparam logic [7:0] FLAGS_SWMASK = 8'hf9;

  typedef struct packed {
    logic tx_empty_irq_on;
    logic rx_irq_on;
    logic xmit_on;
    logic rcv_on;
    logic id_wait_on;
    logic tx_done_irq_on;
    logic [1:0] clk_sel;
  } line_ctrl_word_t;

  typedef struct packed {
    logic rsv_hi;
    logic chr7;
    logic par_on;
    logic par_odd;
    logic stop2;
    logic mp_fmt;
    logic [1:0] rsv_lo;
  } line_format_word_t;

  typedef struct packed {
    logic tx_hold_empty;
    logic rx_hold_full;
    logic overrun_flag;
    logic framing_fault;
    logic parity_fault;
    logic tx_finished;
    logic id_flag_in;
    logic id_flag_out;
  } line_flags_word_t;

  localparam line_ctrl_word_t CTRL_RST = 8'h00;
  localparam line_format_word_t FMT_RST = 8'h00;
  localparam line_flags_word_t FLAGS_RST = 8'h84;
  localparam logic [7:0] BAUD_RST = 8'hff;
  localparam logic [7:0] TXBUF_RST = 8'hff;
  localparam logic [7:0] RXBUF_RST = 8'h00;

  typedef enum logic [2:0] {TX_IDLE, TX_PREAMBLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

endpackage

// file: design/line_unit.sv
// Asynchronous serial transmitter and receiver with an AHB-Lite register slave
module line_unit (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // Serial pins
  output logic TXD_O,
  output logic TXD_OE_N,
  input wire logic RXD_I,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_N,
  // Interrupt requests
  output logic TX_EMPTY_IRQ,
  output logic TX_DONE_IRQ,
  output logic RX_FULL_IRQ,
  output logic RX_FAULT_IRQ
);
  import line_unit_pkg::*;

  line_ctrl_word_t line_ctrl_word_q;
  line_format_word_t line_format_word_q;
  line_flags_word_t line_flags_word_q;
  logic [7:0] baud_divisor_q;
  logic [7:0] tx_hold_buf_q;
  logic [7:0] rx_hold_buf_q;

  logic dp_wr_q;
  logic [4:0] dp_addr_q;
  logic ap_valid;
  logic wr_flags;
  logic [7:0] rd_mux;

  logic [7:0] baud_cnt_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  logic rxd_s1_q, rxd_s2_q, rxd_s3_q;
  logic tick;
  logic [3:0] tx_ph_q;
  logic tx_bit_end;

  tx_state_t tx_state_q;
  logic [7:0] tx_shifter_q;
  logic [3:0] tx_cnt_q;
  logic tx_line_q;
  logic tx_extra_q;
  logic xmit_prev_q;
  logic tx_load, tx_finish, tx_stop_last;

  rx_state_t rx_state_q;
  logic [7:0] rx_shifter_q;
  logic [2:0] rx_cnt_q;
  logic [3:0] rx_ph_q;
  logic rx_extra_q;
  logic rx_sample, rx_done, rx_stop_ok, rx_par_bad, rx_err_any;

  logic has_extra;
  logic [2:0] last_idx;
  logic [3:0] frame_bits;
  logic [7:0] tx_data_masked;

  // Frame shape; multiprocessor format overrides the parity enable
  assign has_extra = line_format_word_q.mp_fmt | line_format_word_q.par_on; // R28
  assign last_idx = line_format_word_q.chr7 ? 3'h6 : 3'h7;
  assign frame_bits = 4'h2 + {1'b0, last_idx} + {3'h0, has_extra}
                      + {3'h0, line_format_word_q.stop2};
  assign tx_data_masked = line_format_word_q.chr7 ? {1'b0, tx_hold_buf_q[6:0]} : tx_hold_buf_q;

  // AHB-Lite slave: zero wait states, always OKAY
  assign ap_valid = HSEL & HTRANS[1] & HREADY;
  assign wr_flags = dp_wr_q & (dp_addr_q == OFF_FLAGS);

  always_comb begin
    case (HADDR[4:0])
      OFF_CTRL: rd_mux = line_ctrl_word_q;
      OFF_FMT: rd_mux = line_format_word_q;
      OFF_BAUD: rd_mux = baud_divisor_q;
      OFF_FLAGS: rd_mux = line_flags_word_q;
      OFF_TXBUF: rd_mux = tx_hold_buf_q;
      OFF_RXBUF: rd_mux = rx_hold_buf_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 5'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      dp_wr_q <= ap_valid & HWRITE;
      dp_addr_q <= HADDR[4:0];
      HRDATA <= (ap_valid & ~HWRITE & (HADDR[31:5] == 27'h0)) ? {24'h00_0000, rd_mux} : 32'h0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Software-written configuration
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      line_ctrl_word_q <= CTRL_RST; // R29
      line_format_word_q <= FMT_RST;
      baud_divisor_q <= BAUD_RST;
      tx_hold_buf_q <= TXBUF_RST;
    end else if (dp_wr_q) begin
      case (dp_addr_q)
        OFF_CTRL: line_ctrl_word_q <= line_ctrl_word_t'(HWDATA[7:0]);
        OFF_FMT: line_format_word_q <= line_format_word_t'(HWDATA[7:0] & FMT_WMASK);
        OFF_BAUD: baud_divisor_q <= HWDATA[7:0];
        OFF_TXBUF: tx_hold_buf_q <= HWDATA[7:0];
        default: ;
      endcase
    end
  end

  // 16x tick: internal divider, or rising edges of the synchronised external clock
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      baud_cnt_q <= BAUD_RST;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
    end else begin
      baud_cnt_q <= (baud_cnt_q == 8'h00) ? baud_divisor_q : baud_cnt_q - 8'h01;
      sck_s1_q <= SCK_I;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
    end
  end

  assign tick = line_ctrl_word_q.clk_sel[1] ? (sck_s2_q & ~sck_s3_q) // R26
                                            : (baud_cnt_q == 8'h00);

  // Free-running transmit bit phase; clock output rises mid-bit
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      tx_ph_q <= 4'h0;
      SCK_O <= 1'b0;
      SCK_OE_N <= 1'b1;
    end else begin
      if (tick) begin
        tx_ph_q <= tx_ph_q + 4'h1;
      end
      SCK_O <= (tx_ph_q >= CLK_OUT_HIGH); // R27
      SCK_OE_N <= ~(~line_ctrl_word_q.clk_sel[1] & (line_ctrl_word_q.clk_sel == CKS_OUT)); // R5
    end
  end

  assign tx_bit_end = tick & (tx_ph_q == LAST_TICK);
  assign tx_stop_last = (tx_state_q == TX_STOP) & (tx_cnt_q == {3'h0, line_format_word_q.stop2});
  assign tx_load = tx_bit_end & line_ctrl_word_q.xmit_on & xmit_prev_q
                   & ~line_flags_word_q.tx_hold_empty
                   & ((tx_state_q == TX_IDLE) | tx_stop_last); // R11 R15
  assign tx_finish = tx_bit_end & line_ctrl_word_q.xmit_on & xmit_prev_q & tx_stop_last
                     & line_flags_word_q.tx_hold_empty; // R15

  // Transmitter
  always_ff @(posedge CORE_CLK) begin
    if (SRST || !line_ctrl_word_q.xmit_on) begin
      tx_state_q <= TX_IDLE; // R1
      tx_shifter_q <= 8'hff;
      tx_cnt_q <= 4'h0;
      tx_line_q <= 1'b1;
      tx_extra_q <= 1'b1;
      xmit_prev_q <= 1'b0;
    end else begin
      xmit_prev_q <= 1'b1;
      if (!xmit_prev_q) begin
        tx_state_q <= TX_PREAMBLE; // R7 R8
        tx_cnt_q <= 4'h0;
        tx_line_q <= 1'b1;
      end else if (tx_load) begin
        tx_shifter_q <= tx_data_masked; // R11
        tx_extra_q <= line_format_word_q.mp_fmt ? line_flags_word_q.id_flag_out
                      : (^tx_data_masked) ^ line_format_word_q.par_odd; // R13
        tx_line_q <= 1'b0; // R12
        tx_state_q <= TX_START;
        tx_cnt_q <= 4'h0;
      end else if (tx_bit_end) begin
        case (tx_state_q)
          TX_PREAMBLE: begin
            // Partial first bit plus frame_bits whole bits of ones, one bit short of a whole frame
            if (tx_cnt_q == frame_bits) begin
              tx_state_q <= TX_IDLE;
            end
            tx_cnt_q <= tx_cnt_q + 4'h1; // R8
          end
          TX_START, TX_DATA: begin
            if (tx_state_q == TX_DATA && tx_cnt_q == {1'b0, last_idx}) begin
              tx_state_q <= has_extra ? TX_PAR : TX_STOP;
              tx_line_q <= has_extra ? tx_extra_q : 1'b1; // R13 R14
              tx_cnt_q <= 4'h0;
            end else begin
              tx_line_q <= tx_shifter_q[0]; // R12
              tx_shifter_q <= {1'b1, tx_shifter_q[7:1]};
              tx_cnt_q <= (tx_state_q == TX_START) ? 4'h0 : tx_cnt_q + 4'h1;
              tx_state_q <= TX_DATA;
            end
          end
          TX_PAR: begin
            tx_state_q <= TX_STOP;
            tx_line_q <= 1'b1; // R14
            tx_cnt_q <= 4'h0;
          end
          TX_STOP: begin
            if (tx_stop_last) begin
              tx_state_q <= TX_IDLE; // R15
            end
            tx_cnt_q <= tx_cnt_q + 4'h1;
            tx_line_q <= 1'b1;
          end
          default: tx_line_q <= 1'b1;
        endcase
      end
    end
  end

  // Receiver
  assign rx_err_any = line_flags_word_q.overrun_flag | line_flags_word_q.framing_fault
                      | line_flags_word_q.parity_fault;
  assign rx_sample = tick & (rx_ph_q == MID_TICK) & (rx_state_q != RX_IDLE)
                     & line_ctrl_word_q.rcv_on; // R2 R25
  assign rx_done = rx_sample & (rx_state_q == RX_STOP);
  assign rx_stop_ok = rxd_s2_q; // R19
  assign rx_par_bad = line_format_word_q.par_on & ~line_format_word_q.mp_fmt
                      & ((^rx_shifter_q) ^ rx_extra_q ^ line_format_word_q.par_odd); // R18 R28

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      rxd_s3_q <= 1'b1;
    end else begin
      rxd_s1_q <= RXD_I;
      rxd_s2_q <= rxd_s1_q;
      rxd_s3_q <= rxd_s2_q;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST || !line_ctrl_word_q.rcv_on) begin
      rx_state_q <= RX_IDLE; // R7 R29
      rx_ph_q <= 4'h0;
      rx_cnt_q <= 3'h0;
      rx_shifter_q <= 8'h00;
      rx_extra_q <= 1'b0;
    end else begin
      if (tick) begin
        rx_ph_q <= rx_ph_q + 4'h1;
      end
      case (rx_state_q)
        RX_IDLE: begin
          if (!rx_err_any && rxd_s3_q && !rxd_s2_q) begin
            rx_state_q <= RX_START; // R17 R23
            rx_ph_q <= 4'h0;
            rx_shifter_q <= 8'h00;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            rx_state_q <= rxd_s2_q ? RX_IDLE : RX_DATA;
            rx_cnt_q <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_shifter_q[rx_cnt_q] <= rxd_s2_q; // R17
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if (rx_cnt_q == last_idx) begin
              rx_state_q <= has_extra ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_sample) begin
            rx_extra_q <= rxd_s2_q;
            rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // Status flags: a hardware set wins over a software clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      line_flags_word_q <= FLAGS_RST; // R29
      rx_hold_buf_q <= RXBUF_RST;
    end else begin
      line_flags_word_q.tx_hold_empty <= (line_flags_word_q.tx_hold_empty
          & ~(wr_flags & ~HWDATA[7])) | tx_load | ~line_ctrl_word_q.xmit_on; // R1 R11
      line_flags_word_q.rx_hold_full <= (line_flags_word_q.rx_hold_full
          & ~(wr_flags & ~HWDATA[6]))
          | (rx_done & ~line_flags_word_q.rx_hold_full & rx_stop_ok & ~rx_par_bad); // R20 R23
      line_flags_word_q.overrun_flag <= (line_flags_word_q.overrun_flag
          & ~(wr_flags & ~HWDATA[5])) | (rx_done & line_flags_word_q.rx_hold_full); // R21
      line_flags_word_q.framing_fault <= (line_flags_word_q.framing_fault
          & ~(wr_flags & ~HWDATA[4]))
          | (rx_done & ~line_flags_word_q.rx_hold_full & ~rx_stop_ok); // R22
      line_flags_word_q.parity_fault <= (line_flags_word_q.parity_fault
          & ~(wr_flags & ~HWDATA[3]))
          | (rx_done & ~line_flags_word_q.rx_hold_full & rx_par_bad); // R22
      line_flags_word_q.tx_finished <= (line_flags_word_q.tx_finished & ~tx_load)
          | tx_finish; // R15
      if (wr_flags) begin
        line_flags_word_q.id_flag_out <= HWDATA[0];
      end
      if (rx_done && !line_flags_word_q.rx_hold_full) begin
        rx_hold_buf_q <= rx_shifter_q; // R20 R22
        line_flags_word_q.id_flag_in <= rx_extra_q;
      end
    end
  end

  // Pin and request outputs
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      TXD_O <= 1'b1;
      TXD_OE_N <= 1'b1;
      TX_EMPTY_IRQ <= 1'b0;
      TX_DONE_IRQ <= 1'b0;
      RX_FULL_IRQ <= 1'b0;
      RX_FAULT_IRQ <= 1'b0;
    end else begin
      TXD_O <= tx_line_q;
      TXD_OE_N <= ~line_ctrl_word_q.xmit_on; // R7
      TX_EMPTY_IRQ <= line_ctrl_word_q.tx_empty_irq_on & line_flags_word_q.tx_hold_empty; // R11
      TX_DONE_IRQ <= line_ctrl_word_q.tx_done_irq_on & line_flags_word_q.tx_finished; // R15
      RX_FULL_IRQ <= line_ctrl_word_q.rx_irq_on & line_flags_word_q.rx_hold_full; // R24
      RX_FAULT_IRQ <= line_ctrl_word_q.rx_irq_on & rx_err_any; // R24
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  te_clear_a: assert property ($fell(line_ctrl_word_q.xmit_on) |=> // R1
    line_flags_word_q.tx_hold_empty && tx_state_q == TX_IDLE && tx_shifter_q == 8'hff)
    else $error("transmit disable did not reset transmitter");
  re_keep_a: assert property ($fell(line_ctrl_word_q.rcv_on) |=> // R2
    $stable(rx_hold_buf_q) && $stable(line_flags_word_q.rx_hold_full) && $stable(rx_err_any))
    else $error("receive disable changed receive state");
  clk_out_a: assert property (line_ctrl_word_q.clk_sel == CKS_OUT |=> !SCK_OE_N) // R5
    else $error("clock output not enabled");
  preamble_a: assert property (tx_state_q == TX_PREAMBLE |-> tx_line_q) // R8
    else $error("preamble bit not one");
  load_a: assert property (tx_load |=> // R11
    line_flags_word_q.tx_hold_empty && tx_state_q == TX_START && !tx_line_q)
    else $error("hold buffer handoff failed");
  stop_line_a: assert property (tx_state_q inside {TX_STOP, TX_IDLE} |-> tx_line_q) // R14
    else $error("stop or mark bit not one");
  finish_a: assert property (tx_finish |=> line_flags_word_q.tx_finished // R15
    && tx_state_q == TX_IDLE ##1 TX_DONE_IRQ == line_ctrl_word_q.tx_done_irq_on)
    else $error("transmit finish not flagged");
  overrun_a: assert property (rx_done && line_flags_word_q.rx_hold_full |=> // R21
    line_flags_word_q.overrun_flag && $stable(rx_hold_buf_q))
    else $error("overrun not handled");
  framing_a: assert property (rx_done && !line_flags_word_q.rx_hold_full && !rx_stop_ok |=> // R22
    line_flags_word_q.framing_fault && !line_flags_word_q.rx_hold_full
    && rx_hold_buf_q == $past(rx_shifter_q))
    else $error("framing fault not handled");
  err_block_a: assert property (rx_err_any && rx_state_q == RX_IDLE |=> rx_state_q == RX_IDLE) // R23
    else $error("reception started with error set");
  rx_irq_a: assert property (line_flags_word_q.rx_hold_full && line_ctrl_word_q.rx_irq_on // R24
    |=> RX_FULL_IRQ)
    else $error("receive-full request missing");
  mid_sample_a: assert property (rx_state_q == RX_START && $past(rx_state_q) == RX_IDLE // R25
    |-> rx_ph_q == 4'h0)
    else $error("bit phase not aligned to start edge");

endmodule

// file: verification/line_remote.sv
// Remote serial node: drives the receive line and decodes the transmit line
module line_remote (
  // Clock
  input wire logic clk,
  // Serial line
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] cap;
  int n_got;
  longint t0;

  // Sample mid-bit, 16 core cycles per bit, bits after the start bit
  initial begin
    rxd = 1'b1;
    n_got = 0;
    cap = '0;
    forever begin
      @(negedge txd);
      t0 = $time;
      repeat (8) @(posedge clk);
      for (int i = 0; i < 12; i++) begin
        repeat (16) @(posedge clk);
        cap[i] = txd;
      end
      n_got++;
    end
  end

  // One frame LSB first, then back to mark
  task automatic send(input logic [11:0] bits, input int n);
    @(posedge clk);
    for (int k = 0; k < n; k++) begin
      rxd <= bits[k];
      repeat (16) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
endmodule

// file: verification/tb.sv
// Self-checking bench for the serial line unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import line_unit_pkg::*;
  logic clk, srst, hsel, hwrite, hready, hresp, txd_w, rxd, sck;
  logic txd_o, txd_oe_n, sck_o, sck_oe_n, te_irq, td_irq, rf_irq, rx_irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [7:0] rst_v [7] = '{8'h00, 8'h00, 8'hff, 8'h84, 8'h00, 8'h00, 8'h00};
  int n_fail, compares, k;
  longint t_en;

  line_unit DUT (.CORE_CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
    .HRDATA(hrdata), .HRESP(hresp), .TXD_O(txd_o), .TXD_OE_N(txd_oe_n), .RXD_I(rxd),
    .SCK_I(sck), .SCK_O(sck_o), .SCK_OE_N(sck_oe_n), .TX_EMPTY_IRQ(te_irq),
    .TX_DONE_IRQ(td_irq), .RX_FULL_IRQ(rf_irq), .RX_FAULT_IRQ(rx_irq));
  // Pull-up on the line while the unit does not drive it
  assign txd_w = txd_oe_n ? 1'b1 : txd_o;
  line_remote peer (.clk(clk), .txd(txd_w), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // External 16x clock keeps running for the whole run, two core cycles a period
  initial begin
    sck = 1'b0;
    forever #5 sck = ~sck;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic sck_period(input string nm, input logic [31:0] e);
    longint t1;
    @(posedge sck_o);
    t1 = $time;
    @(posedge sck_o);
    chk(nm, e, 32'($time - t1));
  endtask

  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    rdv = hrdata;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rdv & {24'hffffff, m});
  endtask

  task automatic cfg(input logic [7:0] f);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_FMT, f);
    repeat (16) @(posedge clk);
    wr(OFF_CTRL, 8'hf5);
    t_en = $time;
  endtask

  task automatic rx(input logic [11:0] b, input int n);
    peer.send(b, n);
    repeat (4) @(posedge clk);
  endtask

  task automatic txchk(input logic [7:0] f, input logic [7:0] d, input logic id,
                       input logic [9:0] e, input int nb);
    int n0;
    cfg(f);
    n0 = peer.n_got;
    rdc("tx ready", OFF_FLAGS, 8'h80, 8'h80);
    wr(OFF_TXBUF, d);
    wr(OFF_FLAGS, {7'h7c, id});
    wr(OFF_FLAGS, {7'h3c, id});
    for (int i = 0; i < 4000 && peer.n_got == n0; i++) @(posedge clk);
    chk("tx frame", {22'h0, e}, {22'h0, peer.cap[9:0]});
    chk("preamble", 32'h1, {31'h0, (peer.t0 - t_en) >= 80 * nb});
    rdc("tx flags", OFF_FLAGS, 8'h84, 8'h84);
    chk("tx done irq", 32'h1, {31'h0, td_irq});
  endtask

  task automatic final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    final_report;
  end

  initial begin
    srst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = '0;
    hwdata = '0;
    n_fail = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (k = 0; k < 7; k++) begin
      if (k != 4) begin
        rdc("reset value", 5'(k * 4), 8'hff, rst_v[k]);
      end
    end
    chk("idle pins", 32'h7, {28'h0, hresp, txd_o, txd_oe_n, sck_oe_n});
    chk("idle irqs", 32'h0, {28'h0, te_irq, td_irq, rf_irq, rx_irq});
    wr(OFF_CTRL, 8'h01);
    repeat (2) @(posedge clk);
    chk("clock out", 32'h0, {31'h0, sck_oe_n});
    wr(OFF_BAUD, 8'h00);
    cfg(8'h00);
    repeat (2) @(posedge clk);
    chk("pins on", 32'h1, {30'h0, txd_oe_n, txd_o});
    chk("empty irq", 32'h1, {31'h0, te_irq});
    sck_period("bit clock", 32'h50);
    // Receive path, 8 data bits, one stop bit
    rx({3'h7, 8'h3c, 1'b0}, 10);
    rdc("rx data", OFF_RXBUF, 8'hff, 8'h3c);
    rdc("rx flags", OFF_FLAGS, 8'hf8, 8'hc0);
    chk("rx full irq", 32'h1, {31'h0, rf_irq});
    rx({3'h7, 8'h81, 1'b0}, 10);
    rdc("overrun data", OFF_RXBUF, 8'hff, 8'h3c);
    rdc("overrun flags", OFF_FLAGS, 8'hf8, 8'he0);
    chk("fault irq", 32'h1, {31'h0, rx_irq});
    wr(OFF_CTRL, 8'he5);
    rdc("kept data", OFF_RXBUF, 8'hff, 8'h3c);
    rdc("kept flags", OFF_FLAGS, 8'hf8, 8'he0);
    wr(OFF_CTRL, 8'hf5);
    wr(OFF_FLAGS, 8'h80);
    rdc("cleared", OFF_FLAGS, 8'hf8, 8'h80);
    rx({3'h6, 8'h5a, 1'b0}, 10);
    rdc("framing data", OFF_RXBUF, 8'hff, 8'h5a);
    rdc("framing flags", OFF_FLAGS, 8'hf8, 8'h90);
    rx({3'h7, 8'h11, 1'b0}, 10);
    rdc("blocked data", OFF_RXBUF, 8'hff, 8'h5a);
    rdc("blocked flags", OFF_FLAGS, 8'hf8, 8'h90);
    wr(OFF_FLAGS, 8'h80);
    cfg(8'h20);
    rx({2'h3, 1'b0, 8'h07, 1'b0}, 11);
    rdc("parity data", OFF_RXBUF, 8'hff, 8'h07);
    rdc("parity flags", OFF_FLAGS, 8'hf8, 8'h88);
    wr(OFF_FLAGS, 8'h80);
    rx({2'h3, 1'b0, 8'h03, 1'b0}, 11);
    rdc("even data", OFF_RXBUF, 8'hff, 8'h03);
    rdc("even flags", OFF_FLAGS, 8'hf8, 8'hc0);
    // Transmit path in three formats
    txchk(8'h00, 8'ha5, 1'b0, 10'h3a5, 10);
    txchk(8'h78, 8'h55, 1'b0, 10'h3d5, 11);
    txchk(8'h24, 8'h0f, 1'b1, 10'h30f, 11);
    // Drop transmit enable in mid-frame
    wr(OFF_TXBUF, 8'h00);
    wr(OFF_FLAGS, 8'h38);
    for (k = 0; k < 400 && txd_o !== 1'b0; k++) @(posedge clk);
    chk("start bit", 32'h0, {31'h0, txd_o});
    repeat (40) @(posedge clk);
    // Second character pending, so only the disable can set the empty flag
    wr(OFF_FLAGS, 8'h38);
    wr(OFF_CTRL, 8'hd5);
    repeat (2) @(posedge clk);
    chk("tx stopped", 32'h3, {30'h0, txd_oe_n, txd_o});
    rdc("empty forced", OFF_FLAGS, 8'h80, 8'h80);
    // External 16x clock: one bit clock per 16 rising edges
    wr(OFF_CTRL, 8'h02);
    sck_period("ext clock", 32'ha0);
    chk("clock in", 32'h1, {31'h0, sck_oe_n});
    final_report;
  end
endmodule
